// File: logic/upt_port_regs.sv
`include "upt_consts.svh"

module upt_port_regs #(
  parameter int ADDR_W = 18
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire upt_pkg::upt_link_s p3_link_raw,
  input  wire upt_pkg::upt_link_s p4_link_raw,
  output logic [2:0]             hs_output_current_adjust,
  output logic [2:0]             squelch_trip_adjust
);

  upt_pkg::upt_regs_s st_q;
  upt_pkg::upt_regs_s st_d;
  upt_pkg::upt_link_s p3_link;
  upt_pkg::upt_link_s p4_link;
  logic [15:0]        idx;
  logic               req;
  logic               done;
  logic [7:0]         boost_val;
  logic [7:0]         squelch_val;
  logic               boost_wr;
  logic               squelch_wr;
  logic [31:0]        rd_word;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word index match for one register
  function automatic logic hits(input logic [15:0] a,
                                input logic [15:0] target);
    hits = (a == target);
  endfunction

  // Status word: state high nibble, bit 3 zero, sub-state low
  function automatic logic [31:0] link_word(
    input upt_pkg::upt_link_s l);
    link_word = '0;
    link_word[`UPT_LS_STATE_MSB:`UPT_LS_STATE_LSB] = l.state;
    link_word[`UPT_LS_RSVD_BIT] = 1'b0;
    link_word[`UPT_LS_SUB_MSB:`UPT_LS_SUB_LSB] = l.sub;
  endfunction

  // Any of the four words of this bank
  function automatic logic mapped(input logic [15:0] a);
    mapped = hits(a, `UPT_IDX_P3_LINK) || hits(a, `UPT_IDX_P4_LINK)
             || hits(a, `UPT_IDX_P4_BOOST)
             || hits(a, `UPT_IDX_P4_SQUELCH);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Link status capture from the link layer

  // Port 3 status path
  upt_link_sync u_p3_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .link_raw (p3_link_raw),
    .link_q   (p3_link)
  );

  // Port 4 status path
  upt_link_sync u_p4_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .link_raw (p4_link_raw),
    .link_q   (p4_link)
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Registers sit one per aligned word
  assign idx  = avs_address[17:2];
  assign req  = avs_read | avs_write;
  assign done = (st_q.bus == upt_pkg::BUS_DONE);

  // Hold the master until the answer cycle
  assign avs_waitrequest = req & ~done;

  // Writes land on the edge that ends the answer cycle
  // boost write strobe
  assign boost_wr = done & avs_write & avs_byteenable[0]
                    & hits(idx, `UPT_IDX_P4_BOOST);
  assign squelch_wr = done & avs_write & avs_byteenable[0]
                      & hits(idx, `UPT_IDX_P4_SQUELCH);

  ////////////////////////////////////////////////////////////////////////
  // Tuning registers of port 4

  // Drive boost keeps every bit it is given
  upt_tune_reg #(
    .RST_VAL (`UPT_BOOST_RST),
    .WMASK   (`UPT_BOOST_WMASK)
  ) u_boost (
    .clk    (clk),
    .arst_n (arst_n),
    .wr_en  (boost_wr),
    .wdata  (avs_writedata[7:0]),
    .value  (boost_val)
  );

  upt_tune_reg #(
    .RST_VAL (`UPT_SQUELCH_RST),
    .WMASK   (`UPT_SQUELCH_WMASK)
  ) u_squelch (
    .clk    (clk),
    .arst_n (arst_n),
    .wr_en  (squelch_wr),
    .wdata  (avs_writedata[7:0]),
    .value  (squelch_val)
  );

  // Fields driven to the port 4 transceiver
  assign hs_output_current_adjust =
    boost_val[`UPT_TUNE_MSB:`UPT_TUNE_LSB];
  assign squelch_trip_adjust =
    squelch_val[`UPT_TUNE_MSB:`UPT_TUNE_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Read multiplexer

  // Unmapped words read as zero
  always_comb begin
    rd_word = '0;
    if (hits(idx, `UPT_IDX_P3_LINK)) begin
      rd_word = link_word(p3_link);
    end
    if (hits(idx, `UPT_IDX_P4_LINK)) begin
      rd_word = link_word(p4_link);
    end
    if (hits(idx, `UPT_IDX_P4_BOOST)) begin
      rd_word = {24'h000000, boost_val};
    end
    if (hits(idx, `UPT_IDX_P4_SQUELCH)) begin
      rd_word = {24'h000000, squelch_val};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Answer sequencer: one wait cycle, then the answer

  // Status registers have no write path at all
  always_comb begin
    st_d = st_q;
    case (st_q.bus)
      upt_pkg::BUS_IDLE: begin
        if (req) begin
          st_d.rdata = avs_read ? rd_word : 32'h00000000;
          st_d.bus   = upt_pkg::BUS_DONE;
        end
      end
      upt_pkg::BUS_DONE: begin
        st_d.bus = upt_pkg::BUS_IDLE;
      end
      default: begin
        st_d.bus = upt_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Read data comes straight from a flip-flop
  assign avs_readdata = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Port 3 status word carries the reported state
  chk_p3_status_word: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!done && avs_read && hits(idx, `UPT_IDX_P3_LINK))
    |=> (avs_readdata[31:8] == 24'h000000)
        && (avs_readdata[3] == 1'b0)
        && (avs_readdata[7:4] == $past(p3_link.state))
        && (avs_readdata[2:0] == $past(p3_link.sub)))
    else $error("Port 3 status word wrong");

  // Port 4 status word carries the reported state
  chk_p4_status_word: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!done && avs_read && hits(idx, `UPT_IDX_P4_LINK))
    |=> (avs_readdata[31:8] == 24'h000000)
        && (avs_readdata[3] == 1'b0)
        && (avs_readdata[7:4] == $past(p4_link.state))
        && (avs_readdata[2:0] == $past(p4_link.sub)))
    else $error("Port 4 status word wrong");

  // Reported states stay inside the defined codes
  chk_link_code_range: assert property (
    @(posedge clk) disable iff (!arst_n)
    (p3_link.state <= `UPT_LS_LOOPBACK)
    && (p4_link.state <= `UPT_LS_LOOPBACK))
    else $error("Undefined link state reported");

  // Boost write reaches the transceiver next cycle
  chk_boost_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    (done && avs_write && avs_byteenable[0]
     && hits(idx, `UPT_IDX_P4_BOOST))
    |=> (hs_output_current_adjust == $past(avs_writedata[2:0]))
        && $stable(squelch_trip_adjust))
    else $error("Boost write not applied");

  // Squelch write reaches the transceiver next cycle
  chk_squelch_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    (done && avs_write && avs_byteenable[0]
     && hits(idx, `UPT_IDX_P4_SQUELCH))
    |=> (squelch_trip_adjust == $past(avs_writedata[2:0]))
        && $stable(hs_output_current_adjust))
    else $error("Squelch write not applied");

  // Squelch reserved bits read back as zero
  chk_squelch_reserved: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!done && avs_read && hits(idx, `UPT_IDX_P4_SQUELCH))
    |=> (avs_readdata[31:3] == 29'h0)
        && (avs_readdata[2:0] == squelch_trip_adjust))
    else $error("Squelch reserved bits not zero");

  // Writes to status words leave the tuning alone
  chk_status_read_only: assert property (
    @(posedge clk) disable iff (!arst_n)
    (done && avs_write
     && (hits(idx, `UPT_IDX_P3_LINK) || hits(idx, `UPT_IDX_P4_LINK)))
    |=> $stable(hs_output_current_adjust)
        && $stable(squelch_trip_adjust))
    else $error("Status write changed tuning");

  // Unmapped words read as zero
  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!done && avs_read && !mapped(idx))
    |=> (avs_readdata == 32'h00000000))
    else $error("Unmapped word not zero");

  // Unmapped writes leave the tuning alone
  chk_unmapped_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    (done && avs_write && !mapped(idx))
    |=> $stable(hs_output_current_adjust)
        && $stable(squelch_trip_adjust))
    else $error("Unmapped write changed tuning");

  // Disabled low byte blocks the write
  chk_byte_gated: assert property (
    @(posedge clk) disable iff (!arst_n)
    (done && avs_write && !avs_byteenable[0])
    |=> $stable(hs_output_current_adjust)
        && $stable(squelch_trip_adjust))
    else $error("Write without byte enable applied");

  // Boost word reads back its field in the low bits
  chk_boost_readback: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!done && avs_read && hits(idx, `UPT_IDX_P4_BOOST))
    |=> (avs_readdata[31:8] == 24'h000000)
        && (avs_readdata[2:0] == hs_output_current_adjust))
    else $error("Boost word wrong");

  // Read data stands outside the take edge
  chk_rdata_stands: assert property (
    @(posedge clk) disable iff (!arst_n)
    !(req && !done) |=> $stable(avs_readdata))
    else $error("Read data changed while idle");

  // A held request is answered after exactly one wait cycle
  chk_wait_single: assert property (
    @(posedge clk) disable iff (!arst_n)
    (req && !done)
    |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("Answer not after one wait cycle");

endmodule

// File: logic/upt_consts.svh
`ifndef UPT_CONSTS_SVH
`define UPT_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define UPT_IDX_P3_LINK      16'h6dc0
`define UPT_IDX_P4_BOOST     16'h70ca
`define UPT_IDX_P4_SQUELCH   16'h70cc
`define UPT_IDX_P4_LINK      16'h71c0

////////////////////////////////////////////////////////////////////////
// Link status field positions
`define UPT_LS_STATE_MSB     7
`define UPT_LS_STATE_LSB     4
`define UPT_LS_RSVD_BIT      3
`define UPT_LS_SUB_MSB       2
`define UPT_LS_SUB_LSB       0

// Tuning field positions
`define UPT_TUNE_MSB         2
`define UPT_TUNE_LSB         0

////////////////////////////////////////////////////////////////////////
// Reset values and writable bit masks of the tuning registers
`define UPT_BOOST_RST        8'h00
`define UPT_SQUELCH_RST      8'h00
`define UPT_BOOST_WMASK      8'hff
`define UPT_SQUELCH_WMASK    8'h07

////////////////////////////////////////////////////////////////////////
// Link state codes
`define UPT_LS_U0            4'h0
`define UPT_LS_U1            4'h1
`define UPT_LS_U2            4'h2
`define UPT_LS_U3            4'h3
`define UPT_LS_DISABLED      4'h4
`define UPT_LS_RX_DETECT     4'h5
`define UPT_LS_INACTIVE      4'h6
`define UPT_LS_POLLING       4'h7
`define UPT_LS_RECOVERY      4'h8
`define UPT_LS_HOT_RESET     4'h9
`define UPT_LS_COMPLIANCE    4'ha
`define UPT_LS_LOOPBACK      4'hb

////////////////////////////////////////////////////////////////////////
// Slave timing: wait cycles before the answer
`define UPT_WAIT_CYCLES      1

`endif

// File: logic/upt_pkg.sv
package upt_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Link status as the link layer reports it
  typedef struct packed {
    logic [3:0] state;
    logic [2:0] sub;
  } upt_link_s;

  // Bus answer sequencer
  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } upt_bus_e;

  ////////////////////////////////////////////////////////////////////////
  // Whole state of the register bank
  typedef struct packed {
    upt_bus_e    bus;
    logic [31:0] rdata;
  } upt_regs_s;

  // Whole state of one status synchroniser
  typedef struct packed {
    upt_link_s s1;
    upt_link_s s2;
    upt_link_s held;
  } upt_sync_s;

  // Whole state of one tuning register
  typedef struct packed {
    logic [7:0] value;
  } upt_tune_s;

endpackage

// File: logic/upt_link_sync.sv
`include "upt_consts.svh"

module upt_link_sync (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire upt_pkg::upt_link_s link_raw,
  output upt_pkg::upt_link_s     link_q
);

  upt_pkg::upt_sync_s st_q;
  upt_pkg::upt_sync_s st_d;

  // Only defined link codes may be reported
  function automatic logic code_ok(input logic [3:0] code);
    code_ok = (code <= `UPT_LS_LOOPBACK);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Two-stage capture, then hold last legal report
  always_comb begin
    st_d    = st_q;
    st_d.s1 = link_raw;
    st_d.s2 = st_q.s1;
    if (code_ok(st_q.s2.state)) begin
      st_d.held = st_q.s2;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link_q = st_q.held;

endmodule

// File: logic/upt_tune_reg.sv
module upt_tune_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK   = 8'hff
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic [7:0]      value
);

  upt_pkg::upt_tune_s st_q;
  upt_pkg::upt_tune_s st_d;

  ////////////////////////////////////////////////////////////////////////
  // Store writable bits only; read-only bits stay zero
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.value = wdata & WMASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q.value <= RST_VAL & WMASK;
    end else begin
      st_q <= st_d;
    end
  end

  assign value = st_q.value;

endmodule

// File: tb/tb_usb_port_tune_link_status.sv
module tb_usb_port_tune_link_status;
  timeunit 1ns;
  timeprecision 1ns;

  // Byte addresses of the four words, plus one unmapped word
  localparam logic [17:0] A_P3 = 18'h1b700;
  localparam logic [17:0] A_BO = 18'h1c328;
  localparam logic [17:0] A_SQ = 18'h1c330;
  localparam logic [17:0] A_P4 = 18'h1c700;
  localparam logic [17:0] A_NO = 18'h00104;

  logic               clk;
  logic               arst_n;
  logic [17:0]        address;
  logic               read;
  logic               write;
  logic [31:0]        wdata;
  logic [3:0]         be;
  logic [31:0]        rdata;
  logic               waitreq;
  upt_pkg::upt_link_s p3_raw;
  upt_pkg::upt_link_s p4_raw;
  logic [2:0]         hs_adj;
  logic [2:0]         sq_adj;
  int                 error_cnt;
  int                 total_checks;

  upt_port_regs #(.ADDR_W(18)) upt_port_regs_inst (
    .clk                      (clk),
    .arst_n                   (arst_n),
    .avs_address              (address),
    .avs_read                 (read),
    .avs_write                (write),
    .avs_writedata            (wdata),
    .avs_byteenable           (be),
    .avs_readdata             (rdata),
    .avs_waitrequest          (waitreq),
    .p3_link_raw              (p3_raw),
    .p4_link_raw              (p4_raw),
    .hs_output_current_adjust (hs_adj),
    .squelch_trip_adjust      (sq_adj)
  );

  // Clock at 10 MHz
  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Closing verdict
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One bus cycle; waitrequest and read data taken at the rising edge
  task automatic bus(input logic rd, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    @(posedge clk);
    address <= a;
    read    <= rd;
    write   <= ~rd;
    wdata   <= d;
    be      <= b;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [17:0] a,
                        input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, 4'h0, q);
    check(what, q, exp);
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    logic [31:0] q;
    bus(1'b0, a, d, b, q);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values of every word and of the tuning outputs
  task automatic t_reset();
    check("boost out", {29'h0, hs_adj}, 32'h0);
    check("squelch out", {29'h0, sq_adj}, 32'h0);
    rd_chk("p3 status", A_P3, 32'h0);
    rd_chk("boost", A_BO, 32'h0);
    rd_chk("squelch", A_SQ, 32'h0);
    rd_chk("p4 status", A_P4, 32'h0);
    rd_chk("unmapped", A_NO, 32'h0);
    $display("Reset test done");
  endtask

  // Every boost code, upper bits stored as read/write
  task automatic t_boost();
    for (int i = 0; i < 8; i++) begin
      wr(A_BO, {24'h0, 5'h15 ^ 5'(i), 3'(i)}, 4'h1);
      @(negedge clk);
      check("boost out", {29'h0, hs_adj}, 32'(i));
      rd_chk("boost", A_BO, {24'h0, 5'h15 ^ 5'(i), 3'(i)});
    end
    $display("Boost test done");
  endtask

  // Every squelch code, reserved bits drop, disabled byte ignored
  task automatic t_squelch();
    for (int i = 0; i < 8; i++) begin
      wr(A_SQ, {24'h0, 5'h1f, 3'(i)}, 4'h1);
      @(negedge clk);
      check("squelch out", {29'h0, sq_adj}, 32'(i));
      rd_chk("squelch", A_SQ, 32'(i));
    end
    wr(A_SQ, 32'h02, 4'he);
    rd_chk("squelch no be", A_SQ, 32'h7);
    $display("Squelch test done");
  endtask

  // Every link state code on both ports, then illegal codes and writes
  task automatic t_link();
    logic [3:0] s3;
    logic [3:0] s4;
    logic [2:0] u3;
    logic [2:0] u4;
    for (int i = 0; i < 12; i++) begin
      s3 = 4'(i);
      s4 = 4'hb - 4'(i);
      u3 = 3'(i) ^ 3'h5;
      u4 = 3'(i);
      @(posedge clk);
      p3_raw <= {s3, u3};
      p4_raw <= {s4, u4};
      repeat (4) @(posedge clk);
      rd_chk("p3 status", A_P3, {24'h0, s3, 1'b0, u3});
      rd_chk("p4 status", A_P4, {24'h0, s4, 1'b0, u4});
    end
    @(posedge clk);
    p3_raw <= {4'hc, 3'h7};
    p4_raw <= {4'hf, 3'h1};
    repeat (4) @(posedge clk);
    rd_chk("p3 held", A_P3, {24'h0, 4'hb, 1'b0, 3'h6});
    rd_chk("p4 held", A_P4, {24'h0, 4'h0, 1'b0, 3'h3});
    wr(A_P3, 32'hff, 4'hf);
    wr(A_P4, 32'hff, 4'hf);
    wr(A_NO, 32'hff, 4'hf);
    check("boost kept", {29'h0, hs_adj}, 32'h7);
    rd_chk("p3 after wr", A_P3, {24'h0, 4'hb, 1'b0, 3'h6});
    rd_chk("p4 after wr", A_P4, {24'h0, 4'h0, 1'b0, 3'h3});
    rd_chk("unmapped", A_NO, 32'h0);
    $display("Link test done");
  endtask

  // Reset in mid-run returns the tuning outputs to nominal
  task automatic t_rerun();
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    check("boost rst", {29'h0, hs_adj}, 32'h0);
    check("squelch rst", {29'h0, sq_adj}, 32'h0);
    @(posedge clk);
    arst_n <= 1'b1;
    rd_chk("boost rst", A_BO, 32'h0);
    $display("Second reset test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    address = 18'h0;
    read = 1'b0;
    write = 1'b0;
    wdata = 32'h0;
    be = 4'h0;
    p3_raw = 7'h0;
    p4_raw = 7'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_boost();
    t_squelch();
    t_link();
    t_rerun();
    test_done();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end

endmodule
